// >>> hpio_pkg.sv
package hpio_pkg;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_TEMP      = 8'h08;
  localparam logic [7:0] ADDR_HOSE      = 8'h0c;
  localparam logic [7:0] ADDR_GRAV      = 8'h10;
  localparam logic [7:0] ADDR_SCHED_HT  = 8'h14;
  localparam logic [7:0] ADDR_SCHED_SB  = 8'h18;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h1c;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h20;
  localparam logic [7:0] ADDR_DISPENSE  = 8'h24;
  // least gap between setback and setpoint, per temperature unit
  localparam logic [8:0]  SB_MIN_F   = 9'h014;
  localparam logic [8:0]  SB_MIN_C   = 9'h00a;
  // zones 1,3,5,7,9,11 sit at bits 0,2,4,6,8,10
  localparam logic [11:0] HOSE_ZONES = 12'h555;
  localparam logic [8:0]  SET_RST    = 9'h15e;
  localparam logic [8:0]  SB_RST     = 9'h12c;
  localparam logic [31:0] ONE_CYCLE  = 32'h0000_0001;

  typedef enum logic [1:0] {
    RUN_OFF = 2'b00, RUN_HEAT = 2'b01, RUN_AT_TEMP = 2'b10, RUN_PUMP = 2'b11
  } hpio_run_e;
  typedef enum logic [1:0] {
    ERR_NONE = 2'b00, ERR_LOW = 2'b01, ERR_EMPTY = 2'b10, ERR_ALARM = 2'b11
  } hpio_err_e;

  typedef struct packed {
    logic primary;
    logic unitC;
    logic sched;
    logic autoStart;
    logic pump;
    logic setback;
    logic heat;
  } hpio_ctrl_s;
  localparam hpio_ctrl_s CTRL_RST = 7'h40;

  typedef struct packed {
    logic autoPump;
    logic plcChange;
    logic cfgErr;
    logic drumEmpty;
    logic alarm;
  } hpio_int_s;

  typedef struct packed {
    logic [16:0] rsvd;
    logic [3:0]  plcIn;
    logic        countMode;
    logic        cfgErr;
    logic        airEn;
    logic        setbackEn;
    logic        heaterEn;
    logic        activeB;
    logic        plcCtrl;
    hpio_err_e   err;
    hpio_run_e   run;
  } hpio_status_s;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } hpio_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hpio_apb_rsp_s;

  typedef struct packed {
    logic [11:0] atTemp;
    logic [11:0] inWindow;
  } hpio_zone_s;
  typedef struct packed {
    logic lowA;
    logic emptyA;
    logic lowB;
    logic emptyB;
    logic alarm;
  } hpio_drum_s;

  typedef struct packed {
    logic [3:0]    s1;
    logic [3:0]    s2;
    logic [3:0]    s3;
    logic [3:0]    plcIn;
    hpio_ctrl_s    ctrl;
    logic [8:0]    tempSet;
    logic [8:0]    tempSb;
    logic [11:0]   hose;
    logic [15:0]   grav;
    logic [21:0]   schHeat;
    logic [21:0]   schSb;
    hpio_int_s     intStat;
    hpio_int_s     intMask;
    logic [31:0]   dispense;
    logic          activeB;
    logic          autoPump;
    logic          alarmPrev;
    logic          emptyPrev;
    logic          plcPrev;
    logic          cfgErr;
    logic          heaterEn;
    logic          setbackEn;
    logic          airEn;
    logic [3:0]    plcOut;
    logic          irq;
    hpio_apb_rsp_s rsp;
  } hpio_state_s;
  localparam hpio_state_s STATE_RST = '{ctrl: CTRL_RST, tempSet: SET_RST,
                                        tempSb: SB_RST, default: '0};
endpackage

// >>> hpio_plc_io_status.sv
`timescale 1ns/1ns
// Contract
// - four outputs: run low, run high, error low, error high
// - error pair: none, active drum low, active drum empty, alarm
// - all outputs open (zero) while unpowered or in reset
// - asserted heat or setback request turns heat or setback on
// - deasserted heat or setback request turns heat or setback off
// - under plc control, display cannot change plc-commanded functions
// - no automatic crossover under plc control; plc decides crossover (there is no plc crossover input; the active unit stays fixed)
// - autostart turns pump on once every zone reaches setpoint
// - setback must sit at least 20F or 10C below setpoint
// - only odd zones 1 to 11 may be hose zones
// - zero specific gravity reports pump cycle count instead of mass
// - schedule switches heat and setback at configured times
// - air motor locked out until all zones within window of setpoint
module hpio_plc_io_status (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  hpio_pkg::hpio_apb_req_s      apbReq,
  output hpio_pkg::hpio_apb_rsp_s      apbRsp,
  input  wire logic [3:0]              plcInPin,
  input  hpio_pkg::hpio_zone_s         zone,
  input  hpio_pkg::hpio_drum_s         drum,
  input  wire logic                    pumpStroke,
  input  wire logic [10:0]             todMin,
  output logic [3:0]                   plcOut,
  output logic                         heaterEn,
  output logic                         setbackEn,
  output logic                         airMotorEn,
  output logic                         irq
);
  import hpio_pkg::*;

  hpio_state_s  q;
  hpio_state_s  d;
  logic         plcCtrl;
  logic         allAt;
  logic         allWin;
  logic         schedHeat;
  logic         schedSb;
  logic         heatReq;
  logic         sbReq;
  logic         pumpReq;
  logic         activeLow;
  logic         activeEmpty;
  logic         cfgNow;
  logic         access;
  logic         fire;
  logic         mapped;
  hpio_err_e    errNow;
  hpio_run_e    runNow;
  hpio_status_s status;
  hpio_int_s    ev;
  hpio_int_s    clr;
  hpio_ctrl_s   newCtrl;
  logic [31:0]  rdData;

  // window may wrap past midnight when start is later than end
  function automatic logic inWin(input logic [10:0] t, input logic [21:0] s);
    logic [10:0] a;
    logic [10:0] b;
    a = s[21:11];
    b = s[10:0];
    inWin = (a <= b) ? (t >= a && t < b) : (t >= a || t < b);
  endfunction

  function automatic logic sbTooHigh(input logic [8:0] sp, input logic [8:0] sb,
                                     input logic unitC);
    logic [9:0] need;
    need = {1'b0, sb} + {1'b0, (unitC ? SB_MIN_C : SB_MIN_F)};
    sbTooHigh = need > {1'b0, sp};
  endfunction

  // only the primary unit listens to the takeover input
  assign plcCtrl     = q.plcIn[3] & q.ctrl.primary;
  assign allAt       = &zone.atTemp;
  assign allWin      = &zone.inWindow;
  assign schedHeat   = inWin(todMin, q.schHeat);
  assign schedSb     = inWin(todMin, q.schSb);
  assign heatReq     = plcCtrl ? q.plcIn[0] :
                       (q.ctrl.sched ? schedHeat : q.ctrl.heat);
  assign sbReq       = plcCtrl ? q.plcIn[1] :
                       (q.ctrl.sched ? schedSb : q.ctrl.setback);
  assign pumpReq     = plcCtrl ? q.plcIn[2] : (q.ctrl.pump | q.autoPump);
  assign activeLow   = q.activeB ? drum.lowB : drum.lowA;
  assign activeEmpty = q.activeB ? drum.emptyB : drum.emptyA;
  assign cfgNow      = sbTooHigh(q.tempSet, q.tempSb, q.ctrl.unitC)
                       | (|(q.hose & ~HOSE_ZONES));
  assign access      = apbReq.psel & apbReq.penable;
  assign fire        = access & q.rsp.pready;

  // alarm outranks drum state, empty outranks low
  assign errNow = drum.alarm ? ERR_ALARM :
                  activeEmpty ? ERR_EMPTY :
                  activeLow ? ERR_LOW : ERR_NONE;
  assign runNow = !q.heaterEn ? RUN_OFF :
                  !allAt ? RUN_HEAT :
                  q.airEn ? RUN_PUMP : RUN_AT_TEMP;

  always_comb begin
    status           = '0;
    status.plcIn     = q.plcIn;
    status.countMode = (q.grav == 16'h0000);
    status.cfgErr    = q.cfgErr;
    status.airEn     = q.airEn;
    status.setbackEn = q.setbackEn;
    status.heaterEn  = q.heaterEn;
    status.activeB   = q.activeB;
    status.plcCtrl   = plcCtrl;
    status.err       = errNow;
    status.run       = runNow;
  end

  always_comb begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    case (apbReq.paddr)
      ADDR_CTRL:     rdData = {25'h0, q.ctrl};
      ADDR_STATUS:   rdData = status;
      ADDR_TEMP:     rdData = {7'h0, q.tempSb, 7'h0, q.tempSet};
      ADDR_HOSE:     rdData = {20'h0, q.hose};
      ADDR_GRAV:     rdData = {16'h0, q.grav};
      ADDR_SCHED_HT: rdData = {10'h0, q.schHeat};
      ADDR_SCHED_SB: rdData = {10'h0, q.schSb};
      ADDR_INT_STAT: rdData = {27'h0, q.intStat};
      ADDR_INT_MASK: rdData = {27'h0, q.intMask};
      ADDR_DISPENSE: rdData = q.dispense;
      default:       mapped = 1'b0;
    endcase
  end

  always_comb begin
    d   = q;
    clr = '0;
    d.s1    = plcInPin;
    d.s2    = q.s1;
    d.s3    = q.s2;
    // a bit changes only once the second and third stages agree
    d.plcIn = (q.s2 & q.s3) | (q.plcIn & (q.s2 | q.s3));

    d.heaterEn  = heatReq;
    d.setbackEn = sbReq;
    // air stays locked until every zone is inside its window
    d.airEn     = pumpReq & q.heaterEn & allWin;
    d.plcOut    = {errNow, runNow};

    if (!q.heaterEn || plcCtrl || !q.ctrl.autoStart)
      d.autoPump = 1'b0;
    else if (allAt && allWin)
      d.autoPump = 1'b1;

    // under plc control the active unit never changes
    d.emptyPrev = activeEmpty;
    if (!plcCtrl && activeEmpty && !q.emptyPrev)
      d.activeB = ~q.activeB;

    d.cfgErr    = cfgNow;
    d.alarmPrev = drum.alarm;
    d.plcPrev   = plcCtrl;

    ev.alarm     = drum.alarm & ~q.alarmPrev;
    ev.drumEmpty = activeEmpty & ~q.emptyPrev;
    ev.cfgErr    = cfgNow & ~q.cfgErr;
    ev.plcChange = plcCtrl ^ q.plcPrev;
    ev.autoPump  = d.autoPump & ~q.autoPump;

    // one wait state: pready rises in the second access cycle
    d.rsp.pready = access & ~q.rsp.pready;
    if (access && !q.rsp.pready) begin
      d.rsp.prdata  = rdData;
      d.rsp.pslverr = ~mapped;
    end

    newCtrl = hpio_ctrl_s'(apbReq.pwdata[6:0]);
    if (plcCtrl) begin
      newCtrl.heat    = q.ctrl.heat;
      newCtrl.setback = q.ctrl.setback;
      newCtrl.pump    = q.ctrl.pump;
    end

    if (fire && apbReq.pwrite) begin
      case (apbReq.paddr)
        ADDR_CTRL:     d.ctrl = newCtrl;
        ADDR_TEMP: begin
          d.tempSet = apbReq.pwdata[8:0];
          d.tempSb  = apbReq.pwdata[24:16];
        end
        ADDR_HOSE:     d.hose = apbReq.pwdata[11:0];
        ADDR_GRAV:     d.grav = apbReq.pwdata[15:0];
        ADDR_SCHED_HT: d.schHeat = apbReq.pwdata[21:0];
        ADDR_SCHED_SB: d.schSb = apbReq.pwdata[21:0];
        ADDR_INT_STAT: clr = hpio_int_s'(apbReq.pwdata[4:0]);
        ADDR_INT_MASK: d.intMask = hpio_int_s'(apbReq.pwdata[4:0]);
        ADDR_DISPENSE: d.dispense = 32'h0000_0000;
        default:       d.ctrl = q.ctrl;
      endcase
    end

    // a stroke in the clearing cycle still counts
    if (pumpStroke)
      d.dispense = d.dispense + ((q.grav == 16'h0000) ? ONE_CYCLE
                                                      : {16'h0, q.grav});
    // a new event wins over a clear in the same cycle
    d.intStat = (q.intStat & ~clr) | ev;
    d.irq     = |(d.intStat & d.intMask);
  end

  always_ff @(posedge sys_clk) begin
    if (reset)
      q <= STATE_RST;
    else
      q <= d;
  end

  assign apbRsp     = q.rsp;
  assign plcOut     = q.plcOut;
  assign heaterEn   = q.heaterEn;
  assign setbackEn  = q.setbackEn;
  assign airMotorEn = q.airEn;
  assign irq        = q.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_out_map;
    plcOut == {$past(errNow), $past(runNow)};
  endproperty
  a_out_map: assert property (p_out_map) else $error("output map wrong");

  property p_alarm;
    drum.alarm |=> plcOut[3:2] == 2'b11;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm code missing");

  property p_run_pump;
    q.airEn && q.heaterEn && allAt |=> plcOut[1:0] == 2'b11;
  endproperty
  a_run_pump: assert property (p_run_pump) else $error("run code wrong");

  property p_reset_open;
    disable iff (1'b0) reset |=> plcOut == 4'h0 && !heaterEn && !airMotorEn;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("outputs not open");

  property p_heat_on;
    plcCtrl && q.plcIn[0] |=> heaterEn;
  endproperty
  a_heat_on: assert property (p_heat_on) else $error("heat not on");

  property p_sb_off;
    plcCtrl && !q.plcIn[1] |=> !setbackEn;
  endproperty
  a_sb_off: assert property (p_sb_off) else $error("setback not off");

  property p_takeover;
    (plcInPin[3] && q.ctrl.primary)[*5] |-> plcCtrl;
  endproperty
  a_takeover: assert property (p_takeover) else $error("takeover missed");

  property p_lock;
    plcCtrl && fire && apbReq.pwrite && apbReq.paddr == ADDR_CTRL
      |=> q.ctrl.heat == $past(q.ctrl.heat);
  endproperty
  a_lock: assert property (p_lock) else $error("display changed heat");

  property p_no_cross;
    plcCtrl |=> q.activeB == $past(q.activeB);
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("auto crossover");

  property p_auto;
    (q.ctrl.autoStart && q.heaterEn && allAt && allWin && !plcCtrl)[*2] |=> airMotorEn;
  endproperty
  a_auto: assert property (p_auto) else $error("autostart failed");

  property p_cfg;
    !q.ctrl.unitC && ({1'b0, q.tempSb} + 10'h014 > {1'b0, q.tempSet}) |=> q.cfgErr;
  endproperty
  a_cfg: assert property (p_cfg) else $error("setback check missed");

  property p_hose;
    |(q.hose & 12'haaa) |=> q.cfgErr;
  endproperty
  a_hose: assert property (p_hose) else $error("even hose zone accepted");

  property p_count;
    q.grav == 16'h0000 && pumpStroke && !fire |=> q.dispense == $past(q.dispense) + 1;
  endproperty
  a_count: assert property (p_count) else $error("cycle count wrong");

  property p_sched;
    q.ctrl.sched && !plcCtrl && schedHeat |=> heaterEn;
  endproperty
  a_sched: assert property (p_sched) else $error("schedule heat missed");

  property p_airlock;
    airMotorEn |-> $past(allWin) && $past(q.heaterEn);
  endproperty
  a_airlock: assert property (p_airlock) else $error("air not locked");

  c_pump: cover property (plcOut[1:0] == 2'b11);
  c_takeover: cover property (!plcCtrl ##1 plcCtrl);
  c_cross: cover property (!q.activeB ##1 q.activeB);
  c_irq: cover property (!irq ##1 irq);
endmodule

// >>> hpio_plc_model.sv
`timescale 1ns/1ns
module hpio_plc_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] want,
  input  wire logic [3:0] plcOut,
  output logic [3:0]      plcInPin
);
  import hpio_pkg::*;
  logic ready;
  assign ready = plcOut[1:0] == RUN_AT_TEMP || plcOut[1:0] == RUN_PUMP;
  always @(posedge sys_clk) begin
    plcInPin[0] <= want[0];
    plcInPin[1] <= want[1];
    // a real controller would not pump into a cold unit
    plcInPin[2] <= want[2] && ready;
    plcInPin[3] <= want[3];
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import hpio_pkg::*;
  logic          sys_clk = 1'b0;
  logic          reset = 1'b1;
  hpio_apb_req_s req = '0;
  hpio_apb_rsp_s apbRsp;
  logic [3:0]    want = '0;
  logic [3:0]    plcInPin;
  logic [3:0]    plcOut;
  hpio_zone_s    zone = '0;
  hpio_drum_s    drum = '0;
  logic          pumpStroke = 1'b0;
  logic [10:0]   todMin = '0;
  logic          heaterEn;
  logic          setbackEn;
  logic          airMotorEn;
  logic          irq;
  logic [31:0]   rdat;
  logic          rerr;
  int            miscompares = 0;
  int            n_compared = 0;

  always #25 sys_clk = ~sys_clk;

  hpio_plc_io_status dut (.sys_clk(sys_clk), .reset(reset), .apbReq(req), .apbRsp(apbRsp),
    .plcInPin(plcInPin), .zone(zone), .drum(drum), .pumpStroke(pumpStroke),
    .todMin(todMin), .plcOut(plcOut), .heaterEn(heaterEn), .setbackEn(setbackEn),
    .airMotorEn(airMotorEn), .irq(irq));
  hpio_plc_model plc (.sys_clk(sys_clk), .want(want), .plcOut(plcOut), .plcInPin(plcInPin));

  task automatic summarize;
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one full transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 20) chk(32'h0000_dead, 32'h0000_0000);
    rdat = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e);
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, 32'hffff_ffff, 32'h0000_0040);
    rd(ADDR_TEMP, 32'hffff_ffff, 32'h012c_015e);
    rd(8'h28, 32'hffff_ffff, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
  endtask

  task automatic t_plc;
    want <= 4'b1001;
    tick(10);
    chk(32'({heaterEn, plcOut}), 32'h0000_0011);
    wr(ADDR_CTRL, 32'h0000_0047);
    rd(ADDR_CTRL, 32'hffff_ffff, 32'h0000_0040);
    want <= 4'b1101;
    zone <= '{atTemp: 12'hfff, inWindow: 12'h7ff};
    tick(12);
    chk(32'({airMotorEn, plcOut}), 32'h0000_0002);
    zone <= '{atTemp: 12'hfff, inWindow: 12'hfff};
    tick(12);
    chk(32'({airMotorEn, plcOut}), 32'h0000_0013);
    want <= 4'b1011;
    tick(10);
    chk(32'({setbackEn, airMotorEn}), 32'h0000_0002);
    want <= 4'b1000;
    tick(10);
    chk(32'({heaterEn, setbackEn, plcOut[1:0]}), 32'h0000_0000);
  endtask

  task automatic t_err;
    logic [4:0] dv [4] = '{5'b00100, 5'b10000, 5'b01000, 5'b00001};
    logic [1:0] ev [4] = '{ERR_NONE, ERR_LOW, ERR_EMPTY, ERR_ALARM};
    for (int i = 0; i < 4; i++) begin
      drum <= dv[i];
      tick(4);
      chk(32'(plcOut[3:2]), 32'(ev[i]));
    end
    rd(ADDR_STATUS, 32'h0000_0020, 32'h0000_0000);
    drum <= '0;
    want <= 4'b0000;
    tick(10);
    drum <= 5'b01000;
    tick(4);
    rd(ADDR_STATUS, 32'h0000_002c, 32'h0000_0020);
    drum <= '0;
  endtask

  task automatic t_cfg;
    wr(ADDR_INT_MASK, 32'h0000_0004);
    wr(ADDR_TEMP, 32'h014b_015e);
    tick(2);
    chk(32'(irq), 32'h0000_0001);
    rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0200);
    wr(ADDR_TEMP, 32'h014a_015e);
    rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0000);
    wr(ADDR_INT_STAT, 32'h0000_0004);
    tick(2);
    chk(32'(irq), 32'h0000_0000);
    wr(ADDR_INT_MASK, 32'h0000_0000);
    wr(ADDR_HOSE, 32'h0000_0002);
    rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0200);
    chk(32'(irq), 32'h0000_0000);
    wr(ADDR_HOSE, 32'h0000_0555);
    rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0000);
    // celsius needs only half the gap, so 340 passes where fahrenheit would not
    wr(ADDR_CTRL, 32'h0000_0060);
    wr(ADDR_TEMP, 32'h0155_015e);
    rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0200);
    wr(ADDR_TEMP, 32'h0154_015e);
    rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0000);
  endtask

  task automatic t_disp;
    wr(ADDR_DISPENSE, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      pumpStroke <= 1'b1;
      tick(1);
      pumpStroke <= 1'b0;
      tick(1);
    end
    rd(ADDR_DISPENSE, 32'hffff_ffff, 32'h0000_0002);
    rd(ADDR_STATUS, 32'h0000_0400, 32'h0000_0400);
    wr(ADDR_GRAV, 32'h0000_0005);
    wr(ADDR_DISPENSE, 32'h0000_0000);
    pumpStroke <= 1'b1;
    tick(1);
    pumpStroke <= 1'b0;
    rd(ADDR_DISPENSE, 32'hffff_ffff, 32'h0000_0005);
  endtask

  task automatic t_auto;
    wr(ADDR_CTRL, 32'h0000_0049);
    tick(4);
    rd(ADDR_STATUS, 32'h0000_0103, 32'h0000_0103);
    wr(ADDR_SCHED_HT, 32'h0003_20c8);
    wr(ADDR_SCHED_SB, 32'h0003_20c8);
    todMin <= 11'h096;
    wr(ADDR_CTRL, 32'h0000_0050);
    tick(3);
    rd(ADDR_STATUS, 32'h0000_00c0, 32'h0000_00c0);
    todMin <= 11'h0fa;
    tick(3);
    rd(ADDR_STATUS, 32'h0000_00c0, 32'h0000_0000);
  endtask

  initial begin
    tick(6);
    chk(32'({irq, airMotorEn, setbackEn, heaterEn, plcOut}), 32'h0000_0000);
    reset <= 1'b0;
    tick(1);
    t_regs();
    t_plc();
    t_err();
    t_cfg();
    t_disp();
    t_auto();
    summarize();
  end

  // whole run needs well under two thousand cycles
  initial begin
    tick(20000);
    miscompares++;
    summarize();
  end
endmodule
